// *** src/tbpd_top.sv ***
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module tbpd_top (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     ce,
    input  wire logic [tbpd_pkg::AW-1:0]  s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output var  logic                     s_axi_awready,
    input  wire logic [tbpd_pkg::DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output var  logic                     s_axi_wready,
    output var  logic [1:0]               s_axi_bresp,
    output var  logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [tbpd_pkg::AW-1:0]  s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output var  logic                     s_axi_arready,
    output var  logic [tbpd_pkg::DW-1:0]  s_axi_rdata,
    output var  logic [1:0]               s_axi_rresp,
    output var  logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic [tbpd_pkg::PINS-1:0] pin_in,
    output var  logic [tbpd_pkg::PINS-1:0] pin_out,
    output var  logic [tbpd_pkg::PINS-1:0] pin_oe,
    output var  logic [tbpd_pkg::PINS-1:0] kbd_level
);
    import tbpd_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [PINS-1:0] pin_data_latch_r;
    logic [PINS-1:0] port_pin_direction_r;
    logic [PINS-1:0] keypad_irq_enable_r;

    logic            aw_have_r;
    logic            aw_have_nxt;
    logic [AW-1:0]   awaddr_r;
    logic            w_have_r;
    logic            w_have_nxt;
    logic [DW-1:0]   wdata_r;
    logic [3:0]      wstrb_r;
    logic            bvalid_nxt;
    logic            aw_hs;
    logic            w_hs;
    logic            wr_fire;
    tbpd_sel_t       wr_sel;

    tbpd_rd_t        rd_state_r;
    tbpd_rd_t        rd_state_nxt;
    logic            ar_hs;
    logic [DW-1:0]   rd_word;
    logic [1:0]      rd_resp;
    logic [PINS-1:0] port_view;

    tbpd_pin_if pif ();

    // ------------------------------------------------------------
    // Pin side
    // ------------------------------------------------------------
    tbpd_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin_in  (pin_in),
        .pif     (pif.sync_mp)
    );

    tbpd_drv u_drv (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .pif       (pif.drv_mp),
        .pin_out   (pin_out),
        .pin_oe    (pin_oe),
        .kbd_level (kbd_level)
    );

    assign pif.latch = pin_data_latch_r;
    assign pif.dir   = port_pin_direction_r;
    assign pif.kie   = keypad_irq_enable_r;

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    // Address and data are taken in either order; the write lands
    // one cycle after both are held, on the same edge that raises the response.
    assign aw_hs   = s_axi_awvalid & s_axi_awready;
    assign w_hs    = s_axi_wvalid & s_axi_wready;
    assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
    assign wr_sel  = tbpd_decode(awaddr_r);

    always_comb begin
        aw_have_nxt = aw_hs ? 1'b1 : (wr_fire ? 1'b0 : aw_have_r);
        w_have_nxt  = w_hs ? 1'b1 : (wr_fire ? 1'b0 : w_have_r);
        if (wr_fire) begin
            bvalid_nxt = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end else begin
            bvalid_nxt = s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= 4'h0;
        end else if (ce) begin
            aw_have_r     <= aw_have_nxt;
            w_have_r      <= w_have_nxt;
            s_axi_awready <= ~aw_have_nxt & ~bvalid_nxt;
            s_axi_wready  <= ~w_have_nxt & ~bvalid_nxt;
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            s_axi_bvalid <= bvalid_nxt;
            if (wr_fire) begin
                s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // No reset branch: the latches hold their contents across reset
    always_ff @(posedge aclk) begin
        if (ce && wr_fire && wr_sel == SEL_DATA && wstrb_r[0]) begin
            pin_data_latch_r <= wdata_r[PINS-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_pin_direction_r <= DIR_RST;
            keypad_irq_enable_r  <= KIE_RST;
        end else if (ce && wr_fire && wstrb_r[0]) begin
            if (wr_sel == SEL_DIR) begin
                port_pin_direction_r <= wdata_r[PINS-1:0];
            end
            if (wr_sel == SEL_KIE) begin
                keypad_irq_enable_r <= wdata_r[PINS-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign ar_hs = s_axi_arvalid & s_axi_arready;

    // Per pin: latch when its direction bit is set, synchronised level when clear
    assign port_view = (port_pin_direction_r & pin_data_latch_r)
                     | (~port_pin_direction_r & pif.level);

    always_comb begin
        rd_word = '0;
        rd_resp = RESP_OKAY;
        unique case (tbpd_decode(s_axi_araddr))
            SEL_DATA: rd_word[PINS-1:0] = port_view;
            SEL_DIR:  rd_word[PINS-1:0] = port_pin_direction_r;
            SEL_KIE:  rd_word[PINS-1:0] = keypad_irq_enable_r;
            SEL_NONE: rd_resp = RESP_SLVERR;
        endcase
    end

    always_comb begin
        rd_state_nxt = rd_state_r;
        unique case (rd_state_r)
            RD_IDLE: if (ar_hs) begin
                rd_state_nxt = RD_RESP;
            end
            RD_RESP: if (s_axi_rready) begin
                rd_state_nxt = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r    <= RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
        end else if (ce) begin
            rd_state_r    <= rd_state_nxt;
            s_axi_arready <= (rd_state_nxt == RD_IDLE);
            s_axi_rvalid  <= (rd_state_nxt == RD_RESP);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce && ar_hs) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_data_read;
        ar_hs && ce && tbpd_decode(s_axi_araddr) == SEL_DATA;
    endsequence

    sequence s_data_write;
        wr_fire && ce && wr_sel == SEL_DATA && wstrb_r[0];
    endsequence

    sequence s_dir_write;
        wr_fire && ce && wr_sel == SEL_DIR && wstrb_r[0];
    endsequence

    property p_oe_from_dir;
        ce && $past(ce) |-> pin_oe == ($past(port_pin_direction_r) & ~$past(keypad_irq_enable_r));
    endproperty
    a_oe_from_dir: assert property (p_oe_from_dir) else $error("pin enable differs from direction");

    property p_dir_reset;
        disable iff (1'b0) !aresetn |=> port_pin_direction_r == 2'h0 && pin_oe == 2'h0;
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");

    property p_dir_write;
        s_dir_write |=> port_pin_direction_r == $past(wdata_r[1:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_read_output_pins;
        s_data_read |=> s_axi_rvalid
            && ((s_axi_rdata[1:0] & $past(port_pin_direction_r))
                == ($past(pin_data_latch_r) & $past(port_pin_direction_r)));
    endproperty
    a_read_output_pins: assert property (p_read_output_pins) else $error("output pin read wrong");

    property p_read_input_pins;
        s_data_read |=> (s_axi_rdata[1:0] & ~$past(port_pin_direction_r))
                        == ($past(pif.level) & ~$past(port_pin_direction_r))
                        && s_axi_rdata[31:2] == 30'h0;
    endproperty
    a_read_input_pins: assert property (p_read_input_pins) else $error("input pin read wrong");

    property p_latch_write;
        s_data_write |=> pin_data_latch_r == $past(wdata_r[1:0]) && s_axi_bvalid;
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("data latch not written");

    property p_input_write_quiet;
        (s_data_write and (port_pin_direction_r == 2'h0 && keypad_irq_enable_r == 2'h0))
            |=> ##1 (pin_oe == 2'h0 && pin_out == 2'h0) || port_pin_direction_r != 2'h0;
    endproperty
    a_input_write_quiet: assert property (p_input_write_quiet) else $error("input pin was driven");

    property p_keypad_pins;
        ce && $past(ce) |-> kbd_level == ($past(pif.level) & $past(keypad_irq_enable_r))
                            && (pin_oe & $past(keypad_irq_enable_r)) == 2'h0;
    endproperty
    a_keypad_pins: assert property (p_keypad_pins) else $error("keypad pin handling wrong");

    property p_sync_delay;
        ce && $past(ce) && $past(ce, 2) && $past(aresetn) && $past(aresetn, 2)
            |-> pif.level == $past(pin_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchroniser delay wrong");

endmodule : tbpd_top
`default_nettype wire

// *** src/tbpd_pkg.sv ***
package tbpd_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned PINS = 2;
    localparam int unsigned AW   = 8;
    localparam int unsigned DW   = 32;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] DATA_IDX = 6'h0b;
    localparam logic [5:0] DIR_IDX  = 6'h0c;
    localparam logic [5:0] KIE_IDX  = 6'h0d;

    // ------------------------------------------------------------
    // Reset values and answers
    // ------------------------------------------------------------
    localparam logic [PINS-1:0] DIR_RST     = 2'h0;
    localparam logic [PINS-1:0] KIE_RST     = 2'h0;
    localparam logic [1:0]      RESP_OKAY   = 2'h0;
    localparam logic [1:0]      RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_DATA = 2'b01,
        SEL_DIR  = 2'b10,
        SEL_KIE  = 2'b11
    } tbpd_sel_t;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } tbpd_rd_t;

    function automatic tbpd_sel_t tbpd_decode(input logic [AW-1:0] addr);
        tbpd_sel_t sel;
        unique case (addr[AW-1:2])
            DATA_IDX: sel = SEL_DATA;
            DIR_IDX:  sel = SEL_DIR;
            KIE_IDX:  sel = SEL_KIE;
            default:  sel = SEL_NONE;
        endcase
        return sel;
    endfunction : tbpd_decode

endpackage : tbpd_pkg

// *** src/tbpd_pin_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface tbpd_pin_if;
    logic [1:0] level;
    logic [1:0] latch;
    logic [1:0] dir;
    logic [1:0] kie;

    modport sync_mp (output level);
    modport core_mp (input level, output latch, output dir, output kie);
    modport drv_mp  (input level, input latch, input dir, input kie);
endinterface : tbpd_pin_if
`default_nettype wire

// *** src/tbpd_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbpd_sync (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    input  wire logic [1:0] pin_in,
    tbpd_pin_if.sync_mp     pif
);
    import tbpd_pkg::*;

    // ------------------------------------------------------------
    // Two-stage synchroniser, one per pin
    // ------------------------------------------------------------
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        logic meta_r;
        logic level_r;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_r  <= 1'b0;
                level_r <= 1'b0;
            end else if (ce) begin
                meta_r  <= pin_in[i];
                level_r <= meta_r;
            end
        end
        assign pif.level[i] = level_r;
    end

endmodule : tbpd_sync
`default_nettype wire

// *** src/tbpd_drv.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbpd_drv (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    tbpd_pin_if.drv_mp      pif,
    output var  logic [1:0] pin_out,
    output var  logic [1:0] pin_oe,
    output var  logic [1:0] kbd_level
);
    import tbpd_pkg::*;

    logic [PINS-1:0] drive;

    // ------------------------------------------------------------
    // Output buffers
    // ------------------------------------------------------------
    // A keypad-enabled pin never drives, whatever its direction bit
    assign drive = pif.dir & ~pif.kie;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe  <= DIR_RST;
            pin_out <= 2'h0;
        end else if (ce) begin
            pin_oe  <= drive;
            // Masked so the latch of a pin that is not driving never reaches the pad
            pin_out <= pif.latch & drive;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kbd_level <= 2'h0;
        end else if (ce) begin
            kbd_level <= pif.level & pif.kie;
        end
    end

endmodule : tbpd_drv
`default_nettype wire

// *** bench/two_bit_port_direction_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module two_bit_port_direction_bench;
    import tbpd_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    localparam logic [AW-1:0] A_DATA = {DATA_IDX, 2'b00};
    localparam logic [AW-1:0] A_DIR  = {DIR_IDX, 2'b00};
    localparam logic [AW-1:0] A_KIE  = {KIE_IDX, 2'b00};
    // Index 0x0f is not decoded
    localparam logic [AW-1:0] A_BAD  = 8'h3c;
    // Whole run needs well under a thousand cycles
    localparam int            LIMIT  = 5000;

    logic            aclk = 1'b0;
    logic            aresetn = 1'b0;
    logic            ce = 1'b1;
    logic [AW-1:0]   s_axi_awaddr = '0;
    logic            s_axi_awvalid = 1'b0;
    logic            s_axi_awready;
    logic [DW-1:0]   s_axi_wdata = '0;
    logic [3:0]      s_axi_wstrb = 4'h0;
    logic            s_axi_wvalid = 1'b0;
    logic            s_axi_wready;
    logic [1:0]      s_axi_bresp;
    logic            s_axi_bvalid;
    logic            s_axi_bready = 1'b0;
    logic [AW-1:0]   s_axi_araddr = '0;
    logic            s_axi_arvalid = 1'b0;
    logic            s_axi_arready;
    logic [DW-1:0]   s_axi_rdata;
    logic [1:0]      s_axi_rresp;
    logic            s_axi_rvalid;
    logic            s_axi_rready = 1'b0;
    logic [PINS-1:0] pin_in = 2'h0;
    logic [PINS-1:0] pin_out;
    logic [PINS-1:0] pin_oe;
    logic [PINS-1:0] kbd_level;
    int              n_errors = 0;
    int              n_tests = 0;
    int              cyc = 0;

    always #10 aclk = ~aclk;

    tbpd_top dut_u (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awprot  (3'h0),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arprot  (3'h0),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .pin_in        (pin_in),
        .pin_out       (pin_out),
        .pin_oe        (pin_oe),
        .kbd_level     (kbd_level)
    );

    // ------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_resp

    task automatic print_verdict();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cyc

    task automatic do_reset();
        aresetn <= 1'b0;
        wait_cyc(16);
        aresetn <= 1'b1;
        wait_cyc(1);
    endtask : do_reset

    // AW and W offered together; each dropped on its own handshake
    task automatic wr(input logic [AW-1:0] a, input logic [1:0] d, input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {30'h0, d};
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk_resp("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input string name, input logic [AW-1:0] a, input logic [1:0] ed, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk_resp("rresp", er, s_axi_rresp);
        chk(name, {30'h0, ed}, s_axi_rdata);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scn_reset();
        rd("dir_after_reset", A_DIR, DIR_RST, RESP_OKAY);
        chk("pin_oe", 32'h0, {30'h0, pin_oe});
        chk("kbd_level", 32'h0, {30'h0, kbd_level});
    endtask : scn_reset

    task automatic scn_input();
        pin_in <= 2'h2;
        wait_cyc(4);
        wr(A_DATA, 2'h1, 4'hf, RESP_OKAY);
        wait_cyc(2);
        chk("pin_oe_input", 32'h0, {30'h0, pin_oe});
        rd("data_input", A_DATA, 2'h2, RESP_OKAY);
    endtask : scn_input

    task automatic scn_output();
        // Latch was loaded before switching direction, so no glitch
        wr(A_DIR, 2'h3, 4'hf, RESP_OKAY);
        rd("dir_rw", A_DIR, 2'h3, RESP_OKAY);
        wait_cyc(2);
        chk("pin_oe_out", 32'h3, {30'h0, pin_oe});
        chk("pin_out", 32'h1, {30'h0, pin_out});
        rd("data_output", A_DATA, 2'h1, RESP_OKAY);
        wr(A_DIR, 2'h1, 4'hf, RESP_OKAY);
        rd("data_mixed", A_DATA, 2'h3, RESP_OKAY);
        wr(A_DATA, 2'h2, 4'hf, RESP_OKAY);
        wait_cyc(2);
        chk("pin_oe_mixed", 32'h1, {30'h0, pin_oe});
        chk("pin_out_mixed", 32'h0, {30'h0, pin_out});
        rd("data_mixed2", A_DATA, 2'h2, RESP_OKAY);
        wr(A_DIR, 2'h3, 4'hf, RESP_OKAY);
        rd("latch_of_input", A_DATA, 2'h2, RESP_OKAY);
    endtask : scn_output

    task automatic scn_refused();
        wr(A_DATA, 2'h1, 4'h0, RESP_OKAY);
        rd("strb_zero", A_DATA, 2'h2, RESP_OKAY);
        wr(A_BAD, 2'h3, 4'hf, RESP_SLVERR);
        rd("unmapped", A_BAD, 2'h0, RESP_SLVERR);
        rd("dir_kept", A_DIR, 2'h3, RESP_OKAY);
    endtask : scn_refused

    task automatic scn_keypad();
        wr(A_KIE, 2'h3, 4'hf, RESP_OKAY);
        pin_in <= 2'h1;
        wait_cyc(5);
        chk("pin_oe_kie", 32'h0, {30'h0, pin_oe});
        chk("kbd_level", 32'h1, {30'h0, kbd_level});
        rd("kie_rw", A_KIE, 2'h3, RESP_OKAY);
        wr(A_KIE, 2'h0, 4'hf, RESP_OKAY);
        wait_cyc(2);
        chk("pin_oe_back", 32'h3, {30'h0, pin_oe});
    endtask : scn_keypad

    task automatic scn_latch_kept();
        do_reset();
        rd("dir_cleared", A_DIR, DIR_RST, RESP_OKAY);
        chk("pin_oe_reset", 32'h0, {30'h0, pin_oe});
        wr(A_DIR, 2'h3, 4'hf, RESP_OKAY);
        rd("latch_kept", A_DATA, 2'h2, RESP_OKAY);
        wait_cyc(2);
        chk("pin_out_kept", 32'h2, {30'h0, pin_out});
    endtask : scn_latch_kept

    task automatic scn_freeze();
        wr(A_DIR, 2'h0, 4'hf, RESP_OKAY);
        wait_cyc(4);
        // Both flops hold 2'h1 while the enable is low
        ce     <= 1'b0;
        pin_in <= 2'h2;
        wait_cyc(4);
        ce <= 1'b1;
        rd("frozen_level", A_DATA, 2'h1, RESP_OKAY);
        rd("released_level", A_DATA, 2'h2, RESP_OKAY);
        chk("pin_oe_freeze", 32'h0, {30'h0, pin_oe});
    endtask : scn_freeze

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        do_reset();
        scn_reset();
        scn_input();
        scn_output();
        scn_refused();
        scn_keypad();
        scn_latch_kept();
        scn_freeze();
        print_verdict();
    end

endmodule : two_bit_port_direction_bench
`default_nettype wire
